// File: ctu_timer.sv
/*
  four-channel capture timer with APB register access, compare outputs,
  and adc trigger / comparator strobe taken from the second channel.
  assumes capture pins are asynchronous and the APB master shares mclk.
*/
`timescale 1ns/100ps
`default_nettype none

module ctu_timer (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ctu_pkg::CTU_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // pins
  input  wire logic [ctu_pkg::CTU_NUM_CH-1:0] capture_pin,
  output wire logic [ctu_pkg::CTU_NUM_CH-1:0] compare_output,
  output var  logic                          adc_trigger,
  output var  logic                          comparator_strobe
);
  import ctu_pkg::*;

  // ==========================================================================
  // functions
  function automatic logic [7:0] div_mask(input logic [2:0] code);
    div_mask = 8'((9'h001 << code) - 9'h001);
  endfunction

  // ==========================================================================
  // bus decode
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  ctu_trig_t        trig_q;
  ctu_trig_t        trig_d;
  logic [15:0]      adcpt_q;
  logic [15:0]      cmppt_q;
  logic             adc_trig_q;
  logic             cmp_strobe_q;
  logic [31:0]      rd_ch [CTU_NUM_CH];
  logic [15:0]      cnt_w [CTU_NUM_CH];
  logic             adv_w [CTU_NUM_CH];
  logic [31:0]      rd_data_w;

  wire              setup_w    = psel & ~penable;
  wire              acc_w      = psel & penable & pready_q;
  wire              wr_w       = acc_w & pwrite;
  wire              chan_area  = (paddr[11:7] == 5'h00);
  wire [1:0]        ch_idx     = paddr[6:5];
  wire [4:0]        off        = paddr[4:0];
  wire              aligned    = (paddr[1:0] == 2'h0);
  wire              hit_trig   = (paddr == CTU_ADR_TRIG);
  wire              hit_adcpt  = (paddr == CTU_ADR_ADCPT);
  wire              hit_cmppt  = (paddr == CTU_ADR_CMPPT);
  wire              addr_ok    = aligned & ((chan_area & (off <= CTU_OFF_PERIOD)) | hit_trig | hit_adcpt | hit_cmppt);
  wire [31:0]       rd_misc    = hit_trig  ? {29'h0, trig_q} :
                                 hit_adcpt ? {16'h0, adcpt_q} :
                                 hit_cmppt ? {16'h0, cmppt_q} : 32'h0;

  assign rd_data_w = !addr_ok ? 32'h0 : chan_area ? rd_ch[ch_idx] : rd_misc;

  // ==========================================================================
  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~addr_ok;
      if (setup_w)
        prdata_q <= pwrite ? 32'h0 : rd_data_w;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // channels
  for (genvar i = 0; i < CTU_NUM_CH; i++)
  begin : g_ch
    ctu_ctrl_t   ctrl_q;
    ctu_ctrl_t   ctrl_d;
    ctu_flags_t  flg_q;
    ctu_flags_t  flg_set;
    ctu_state_t  st_q;
    ctu_state_t  st_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cmpw_q;
    logic [15:0] cmpw_d;
    logic [15:0] per_q;
    logic [15:0] per_d;
    logic [15:0] tally_q;
    logic [15:0] tally_d;
    logic [7:0]  pre_q;
    logic [1:0]  sync_q;
    logic [1:0]  flt_cnt_q;
    logic        flt_q;
    logic        prev_q;
    logic        oc_q;
    logic        oc_d;
    logic        stop;

    wire         sel_ch   = wr_w & chan_area & (ch_idx == 2'(i));
    wire         wr_ctrl  = sel_ch & (off == CTU_OFF_CTRL);
    wire         wr_stat  = sel_ch & (off == CTU_OFF_STAT);
    wire         wr_cnt   = sel_ch & (off == CTU_OFF_COUNT);
    wire         wr_cmpw  = sel_ch & (off == CTU_OFF_CMPW);
    wire         wr_per   = sel_ch & (off == CTU_OFF_PERIOD);
    wire [7:0]   mask     = div_mask(ctrl_q.divider);
    wire         tick     = ((pre_q & mask) == mask);
    wire         in_sel   = ctrl_q.filter_on ? flt_q : sync_q[1];
    wire         rise     = in_sel & ~prev_q;
    wire         fall     = ~in_sel & prev_q;
    wire         vedge    = ctrl_q.edge_sel ? rise : fall;
    wire [15:0]  tally_n  = tally_q + 16'h0001;
    wire         cnt_le   = (cnt_q <= cmpw_q);
    wire [2:0]   flg_clr  = wr_stat ? ~pwdata[CTU_FLAG_W-1:0] : 3'h0;

    // sequencing of the three working modes
    always_comb
    begin
      flg_set = '0;
      stop    = 1'b0;
      cnt_d   = cnt_q;
      cmpw_d  = cmpw_q;
      per_d   = per_q;
      tally_d = tally_q;
      st_d    = st_q;
      if (!ctrl_q.run)
        st_d = CTU_ST_WAIT;
      else if (ctrl_q.output_mode)
      begin
        st_d = CTU_ST_COUNT;
        if (tick)
        begin
          if (cnt_q == cmpw_q)
            flg_set.match = 1'b1;
          if (cnt_q == per_q)
          begin
            flg_set.overflow = 1'b1;
            cnt_d            = CTU_CNT_RST;
            stop             = ctrl_q.single_shot;
          end
          else
            cnt_d = cnt_q + 16'h0001;
        end
      end
      else if (st_q == CTU_ST_WAIT)
      begin
        if (ctrl_q.counter_mode ? vedge : rise)
        begin
          cnt_d   = CTU_CNT_RST;
          tally_d = CTU_CNT_RST;
          st_d    = CTU_ST_COUNT;
        end
      end
      else if (!ctrl_q.counter_mode && rise)
      begin
        per_d          = cnt_q;
        flg_set.period = 1'b1;
        cnt_d          = CTU_CNT_RST;
        stop           = ctrl_q.single_shot;
      end
      else if (ctrl_q.counter_mode && vedge && (tally_n == cmpw_q))
      begin
        per_d          = cnt_q;
        flg_set.period = 1'b1;
        cnt_d          = CTU_CNT_RST;
        tally_d        = CTU_CNT_RST;
        stop           = ctrl_q.single_shot;
      end
      else
      begin
        if (ctrl_q.counter_mode && vedge)
          tally_d = tally_n;
        if (!ctrl_q.counter_mode && fall)
        begin
          cmpw_d        = cnt_q;
          flg_set.match = 1'b1;
        end
        if (tick)
        begin
          if (cnt_q == CTU_CNT_MAX)
          begin
            flg_set.overflow = 1'b1;
            cnt_d            = CTU_CNT_RST;
            stop             = ctrl_q.single_shot;
            if (ctrl_q.single_shot && ctrl_q.counter_mode)
              tally_d = CTU_CNT_RST;
          end
          else
            cnt_d = cnt_q + 16'h0001;
        end
      end
      if (stop)
        st_d = CTU_ST_WAIT;
      if (wr_cnt)
        cnt_d = pwdata[15:0];
      if (wr_cmpw)
        cmpw_d = pwdata[15:0];
      if (wr_per)
        per_d = pwdata[15:0];
    end

    always_comb
    begin
      ctrl_d     = ctrl_q;
      ctrl_d.run = ctrl_q.run & ~stop;
      if (wr_ctrl)
        ctrl_d = ctu_ctrl_t'(pwdata[CTU_CTRL_W-1:0]);
    end

    // compare output level
    always_comb
    begin
      unique case (ctrl_q.ocs)
        2'h0:    oc_d = 1'b0;
        2'h1:    oc_d = 1'b1;
        2'h2:    oc_d = ~cnt_le;
        2'h3:    oc_d = cnt_le;
      endcase
      if (!ctrl_q.output_mode)
        oc_d = 1'b0;
    end

    // input synchroniser, 4-cycle glitch filter and edge memory
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        sync_q    <= 2'h0;
        flt_q     <= 1'b0;
        flt_cnt_q <= 2'h0;
        prev_q    <= 1'b0;
      end
      else
      begin
        sync_q    <= {sync_q[0], capture_pin[i]};
        flt_cnt_q <= (sync_q[1] != flt_q) ? flt_cnt_q + 2'h1 : 2'h0;
        if ((sync_q[1] != flt_q) && (flt_cnt_q == CTU_FLT_LAST))
          flt_q <= sync_q[1];
        prev_q    <= in_sel;
      end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        ctrl_q  <= CTU_CTRL_RST;
        flg_q   <= CTU_FLAG_RST;
        st_q    <= CTU_ST_WAIT;
        cnt_q   <= CTU_CNT_RST;
        cmpw_q  <= CTU_CNT_RST;
        per_q   <= CTU_CNT_RST;
        tally_q <= CTU_CNT_RST;
        pre_q   <= CTU_PRE_RST;
        oc_q    <= 1'b0;
      end
      else
      begin
        ctrl_q  <= ctrl_d;
        flg_q   <= ctu_flags_t'((flg_q & ~flg_clr) | flg_set);
        st_q    <= st_d;
        cnt_q   <= cnt_d;
        cmpw_q  <= cmpw_d;
        per_q   <= per_d;
        tally_q <= tally_d;
        pre_q   <= pre_q + 8'h01;
        oc_q    <= oc_d;
      end
    end

    assign compare_output[i] = oc_q;
    assign cnt_w[i]          = cnt_q;
    assign adv_w[i]          = tick & ctrl_q.run;
    assign rd_ch[i]          = (off == CTU_OFF_CTRL)   ? {21'h0, ctrl_q} :
                               (off == CTU_OFF_STAT)   ? {tally_q, 12'h0, (st_q == CTU_ST_COUNT), flg_q} :
                               (off == CTU_OFF_COUNT)  ? {16'h0, cnt_q} :
                               (off == CTU_OFF_CMPW)   ? {16'h0, cmpw_q} :
                               (off == CTU_OFF_PERIOD) ? {16'h0, per_q} : 32'h0;
  end

  // ==========================================================================
  // adc trigger and comparator strobe from the second channel
  wire              wr_trig   = wr_w & hit_trig;
  wire              adc_hit   = trig_q.adc_en & adv_w[CTU_SECOND_CH] & (cnt_w[CTU_SECOND_CH] == adcpt_q);
  wire              cmp_hit   = trig_q.cmp_en & adv_w[CTU_SECOND_CH] & (cnt_w[CTU_SECOND_CH] == cmppt_q);

  always_comb
  begin
    trig_d = trig_q;
    if (wr_trig)
    begin
      trig_d.adc_en   = pwdata[0];
      trig_d.cmp_en   = pwdata[1];
      trig_d.adc_flag = trig_q.adc_flag & pwdata[2];
    end
    if (adc_hit)
      trig_d.adc_flag = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      trig_q       <= CTU_TRIG_RST;
      adcpt_q      <= CTU_CNT_RST;
      cmppt_q      <= CTU_CNT_RST;
      adc_trig_q   <= 1'b0;
      cmp_strobe_q <= 1'b0;
    end
    else
    begin
      trig_q       <= trig_d;
      adc_trig_q   <= adc_hit;
      cmp_strobe_q <= cmp_hit;
      if (wr_w & hit_adcpt)
        adcpt_q <= pwdata[15:0];
      if (wr_w & hit_cmppt)
        cmppt_q <= pwdata[15:0];
    end
  end

  assign adc_trigger       = adc_trig_q;
  assign comparator_strobe = cmp_strobe_q;

endmodule

`default_nettype wire

// File: ctu_pkg.sv
/*
  package for the four-channel capture timer unit: register map, field layouts,
  reset values, channel states and timing constants.
  assumes a single 125 MHz clock domain and an APB master on the register side.
*/

package ctu_pkg;

  // ==========================================================================
  // geometry
  localparam int unsigned CTU_NUM_CH     = 4;
  localparam int unsigned CTU_SECOND_CH  = 1;
  localparam int unsigned CTU_ADDR_W     = 12;

  // ==========================================================================
  // register offsets (channel block at ch*0x20, shared trigger block above)
  localparam logic [4:0]  CTU_OFF_CTRL   = 5'h00;
  localparam logic [4:0]  CTU_OFF_STAT   = 5'h04;
  localparam logic [4:0]  CTU_OFF_COUNT  = 5'h08;
  localparam logic [4:0]  CTU_OFF_CMPW   = 5'h0C;
  localparam logic [4:0]  CTU_OFF_PERIOD = 5'h10;
  localparam logic [11:0] CTU_ADR_TRIG   = 12'h080;
  localparam logic [11:0] CTU_ADR_ADCPT  = 12'h084;
  localparam logic [11:0] CTU_ADR_CMPPT  = 12'h088;

  // ==========================================================================
  // field positions
  localparam int unsigned CTU_CTRL_W     = 11;
  localparam int unsigned CTU_FLAG_W     = 3;
  localparam int unsigned CTU_STAT_ST    = 3;
  localparam int unsigned CTU_STAT_TALLY = 16;
  localparam int unsigned CTU_TRIG_W     = 3;

  // ==========================================================================
  // reset values and timing counts
  localparam logic [15:0] CTU_CNT_RST    = 16'h0000;
  localparam logic [15:0] CTU_CNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  CTU_PRE_RST    = 8'h00;
  localparam logic [1:0]  CTU_FLT_LAST   = 2'h3;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       filter_on;
    logic       single_shot;
    logic       run;
    logic [2:0] divider;
    logic [1:0] ocs;
    logic       edge_sel;
    logic       counter_mode;
    logic       output_mode;
  } ctu_ctrl_t;

  typedef struct packed {
    logic overflow;
    logic period;
    logic match;
  } ctu_flags_t;

  typedef struct packed {
    logic adc_flag;
    logic cmp_en;
    logic adc_en;
  } ctu_trig_t;

  typedef enum logic {CTU_ST_WAIT, CTU_ST_COUNT} ctu_state_t;

  localparam ctu_ctrl_t  CTU_CTRL_RST  = '0;
  localparam ctu_flags_t CTU_FLAG_RST  = '0;
  localparam ctu_trig_t  CTU_TRIG_RST  = '0;

endpackage

// File: ctu_timer_asserts.sv
/*
  port checker for the capture timer: apb handshake, forced compare levels,
  trigger strobes gated by their enables and by the run bit of channel 1.
  assumes the register map of ctu_pkg and one mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module ctu_timer_asserts (
  // clock and reset
  input wire logic                             mclk,
  input wire logic                             rst,
  // apb
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [ctu_pkg::CTU_ADDR_W-1:0]   paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic [31:0]                      prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  // pins
  input wire logic [ctu_pkg::CTU_NUM_CH-1:0]   capture_pin,
  input wire logic [ctu_pkg::CTU_NUM_CH-1:0]   compare_output,
  input wire logic                             adc_trigger,
  input wire logic                             comparator_strobe
);
  import ctu_pkg::*;
  // ==========================================================================
  // shadow of written control values
  logic [10:0] ctl0_q;
  logic [10:0] ctl1_q;
  logic [2:0]  trg_q;
  logic [1:0]  age_q;
  wire         wr_done = psel && penable && pwrite && pready;
  wire  [1:0]  age_d   = wr_done ? 2'h0 : ((age_q == 2'h3) ? age_q : age_q + 2'h1);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctl0_q <= '0;
      ctl1_q <= '0;
      trg_q  <= '0;
      age_q  <= '0;
    end
    else
    begin
      age_q  <= age_d;
      ctl0_q <= (wr_done && paddr == 12'h000) ? pwdata[10:0] : ctl0_q;
      ctl1_q <= (wr_done && paddr == 12'h020) ? pwdata[10:0] : ctl1_q;
      trg_q  <= (wr_done && paddr == CTU_ADR_TRIG) ? pwdata[2:0] : trg_q;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence settled_s;
    age_q == 2'h3;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  a_err_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read data not zero");
  a_force_low: assert property (settled_s ##0 ctl0_q[0] && ctl0_q[4:3] == 2'b00 |-> !compare_output[0])
    else $error("forced low level broken");
  a_force_high: assert property (settled_s ##0 ctl0_q[0] && ctl0_q[4:3] == 2'b01 |-> compare_output[0])
    else $error("forced high level broken");
  a_adc_enabled: assert property (adc_trigger |-> $past(trg_q[0]))
    else $error("adc trigger while disabled");
  a_strobe_enabled: assert property (comparator_strobe |-> $past(trg_q[1]))
    else $error("strobe while disabled");
  a_stopped_quiet: assert property (settled_s ##0 !ctl1_q[8] |-> !adc_trigger && !comparator_strobe)
    else $error("strobe while stopped");
endmodule
bind ctu_timer ctu_timer_asserts u_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .compare_output(compare_output), .adc_trigger(adc_trigger), .comparator_strobe(comparator_strobe)
);
`default_nettype wire

// File: ctu_pin_source.sv
/*
  pwm source on the capture pins: pulse bursts and static levels.
  assumes the caller calls its tasks from the bench, pins driven push-pull.
*/
`timescale 1ns/100ps
`default_nettype none
module ctu_pin_source (
  // clock
  input  wire logic                           mclk,
  // pins
  output var  logic [ctu_pkg::CTU_NUM_CH-1:0] capture_pin
);
  import ctu_pkg::*;
  initial capture_pin = '0;
  // ==========================================================================
  // n pulses of hi cycles high, lo cycles low
  task automatic burst(input logic [3:0] mask, input int hi, input int lo, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      capture_pin <= capture_pin | mask;
      repeat (hi) @(posedge mclk);
      capture_pin <= capture_pin & ~mask;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask
  task automatic drive(input logic [3:0] mask, input logic v);
    @(posedge mclk);
    capture_pin <= v ? (capture_pin | mask) : (capture_pin & ~mask);
  endtask
endmodule
`default_nettype wire

// File: tb_capture_timer_unit.sv
/*
  self-checking bench for the capture timer unit.
  assumes ctu_pkg, ctu_timer, its checker and the pin source are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_capture_timer_unit;
  import ctu_pkg::*;
  localparam logic [11:0] CTRL0 = {7'h00, CTU_OFF_CTRL};
  localparam logic [11:0] STAT0 = {7'h00, CTU_OFF_STAT};
  localparam logic [11:0] CNT0  = {7'h00, CTU_OFF_COUNT};
  localparam logic [11:0] CMP0  = {7'h00, CTU_OFF_CMPW};
  localparam logic [11:0] PER0  = {7'h00, CTU_OFF_PERIOD};
  localparam logic [11:0] CTRL1 = {7'h01, CTU_OFF_CTRL};
  localparam logic [11:0] CNT1  = {7'h01, CTU_OFF_COUNT};
  localparam logic [11:0] PER1  = {7'h01, CTU_OFF_PERIOD};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  capture_pin;
  logic [3:0]  compare_output;
  logic        adc_trigger;
  logic        comparator_strobe;
  logic [31:0] q;
  int          errors = 0;
  int          tests_run = 0;
  int          h;
  int          a;
  int          s;
  ctu_timer uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .compare_output(compare_output), .adc_trigger(adc_trigger), .comparator_strobe(comparator_strobe));
  ctu_pin_source src (.mclk(mclk), .capture_pin(capture_pin));
  always #4 mclk = ~mclk;
  // ==========================================================================
  // common tasks
  task automatic final_report();
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic [31:0] seen, input int exp);
    chk(32'(seen + 1 >= exp && seen <= exp), 32'h0000_0001);
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] rq,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rq = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic e;
    apb(1'b1, ad, d, q, e);
  endtask
  task automatic rd(input logic [11:0] ad);
    logic e;
    apb(1'b0, ad, 32'h0000_0000, q, e);
  endtask
  task automatic watch(input int n);
    h = 0;
    a = 0;
    s = 0;
    repeat (n)
    begin
      @(posedge mclk);
      h += int'(compare_output[0] === 1'b1);
      a += int'(adc_trigger === 1'b1);
      s += int'(comparator_strobe === 1'b1);
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic e;
    apb(1'b0, 12'h0FC, 32'h0000_0000, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    apb(1'b1, 12'h081, 32'hFFFF_FFFF, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    rd(CTU_ADR_TRIG);
    chk(q, 32'h0000_0000);
    rd(CTRL0);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_pwm();
    logic [31:0] c;
    for (int d = 0; d < 8; d++)
    begin
      c = 32'h201 | (32'(d) << 5) | ((d % 2) ? 32'h18 : 32'h10);
      wr(CTRL0, c);
      wr(CNT0, 32'h0);
      wr(CMP0, 32'h3);
      wr(PER0, 32'h9);
      wr(STAT0, 32'h0);
      wr(CTRL0, c | 32'h100);
      watch((12 << d) + 20);
      chk(32'(h), (d % 2) ? 32'((12 << d) + 20 - (6 << d)) : 32'(6 << d));
      rd(STAT0);
      chk(q & 32'h7, 32'h5);
      rd(CTRL0);
      chk(q & 32'h100, 32'h0);
      rd(CNT0);
      chk(q, 32'h0);
    end
  endtask
  task automatic t_force();
    logic [31:0] c;
    for (int o = 0; o < 2; o++)
    begin
      wr(CTRL0, 32'h001 | (32'(o) << 3));
      wr(CNT0, 32'h0);
      wr(CMP0, 32'h2);
      wr(PER0, 32'h5);
      wr(STAT0, 32'h0);
      wr(CTRL0, 32'h101 | (32'(o) << 3));
      watch(30);
      chk(32'(h), 32'(o * 30));
      rd(STAT0);
      chk(q & 32'h5, 32'h5);
      rd(CTRL0);
      chk(q & 32'h100, 32'h100);
    end
    wr(CTRL0, 32'h009);
    rd(CNT0);
    c = q;
    wr(STAT0, 32'h0);
    watch(20);
    rd(STAT0);
    chk(q & 32'h7, 32'h0);
    rd(CNT0);
    chk(q, c);
  endtask
  task automatic t_timer();
    wr(CTRL0, 32'h0);
    wr(STAT0, 32'h0);
    wr(CTRL0, 32'h300);
    src.burst(4'h1, 20, 30, 2);
    watch(10);
    rd(CMP0);
    near(q, 20);
    rd(PER0);
    near(q, 50);
    rd(STAT0);
    chk(q & 32'h7, 32'h3);
    rd(CTRL0);
    chk(q & 32'h100, 32'h0);
    wr(STAT0, 32'h0);
    wr(CTRL0, 32'h100);
    src.burst(4'h1, 5, 5, 1);
    wr(CNT0, 32'hFFF0);
    watch(40);
    rd(STAT0);
    chk(q & 32'h4, 32'h4);
    rd(CNT0);
    chk(32'(q < 32'h40), 32'h1);
  endtask
  task automatic t_filter();
    for (int f = 1; f >= 0; f--)
    begin
      wr(CTRL0, 32'h0);
      wr(STAT0, 32'h0);
      wr(CTRL0, 32'h100 | (32'(f) << 10));
      src.burst(4'h1, 2, 10, 4);
      watch(10);
      rd(STAT0);
      chk(q & 32'h8, f ? 32'h0 : 32'h8);
      src.burst(4'h1, 6, 10, 1);
      rd(STAT0);
      chk(q & 32'h8, 32'h8);
    end
  endtask
  task automatic t_counter();
    for (int es = 0; es < 2; es++)
    begin
      wr(CTRL0, 32'h0);
      wr(STAT0, 32'h0);
      wr(CMP0, 32'h3);
      wr(CTRL0, 32'h302 | (32'(es) << 2));
      src.burst(4'h1, 10, 10, 3);
      src.drive(4'h1, 1'b1);
      watch(10);
      rd(STAT0);
      chk(q & 32'h2, 32'(es * 2));
      if (es == 1)
      begin
        rd(PER0);
        near(q, 60);
      end
      else
      begin
        chk(q >> 16, 32'h2);
        wr(CTRL0, 32'h102);
        wr(CNT0, 32'hFFF0);
        watch(30);
        rd(STAT0);
        chk(q & 32'hFFFF_000C, 32'h0002_000C);
        wr(STAT0, 32'h0);
        wr(CTRL0, 32'h302);
        wr(CNT0, 32'hFFF0);
        watch(30);
        rd(STAT0);
        chk(q & 32'hFFFF_000C, 32'h4);
      end
      src.drive(4'h1, 1'b0);
    end
  endtask
  task automatic t_trigger();
    wr(CTRL1, 32'h009);
    wr(PER1, 32'h14);
    wr(CTU_ADR_ADCPT, 32'h5);
    wr(CTU_ADR_CMPPT, 32'h7);
    for (int en = 1; en < 3; en++)
    begin
      wr(CTU_ADR_TRIG, 32'(en));
      wr(CNT1, 32'h0);
      wr(CTRL1, 32'h109);
      watch(42);
      chk(32'(compare_output), 32'h0000_0002);
      wr(CTRL1, 32'h009);
      chk(32'(a), (en == 1) ? 32'h2 : 32'h0);
      chk(32'(s), (en == 2) ? 32'h2 : 32'h0);
      rd(CTU_ADR_TRIG);
      chk(q & 32'h4, (en == 1) ? 32'h4 : 32'h0);
    end
  endtask
  // ==========================================================================
  // sequence and watchdog
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_pwm();
    t_force();
    t_timer();
    t_filter();
    t_counter();
    t_trigger();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
